// >>> verilog/tss_settle_status.sv
// Transmit settle/spacing register, security status and AXI4-Lite slave
//
// Summary of operation
// - Upper nibble sets settle wait before transmit
// - Lower nibble sets minimum spacing, resets five
// - Settle plus spacing checked against twelve-symbol gap
// - Low battery compares supply, gated by enable
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module tss_settle_status #(
  parameter int SYMBOL_CYCLES = tss_pkg::SYMBOL_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [tss_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [tss_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [tss_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [tss_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        tx_request,
  input  wire logic                        tx_done,
  output logic                             tx_start,
  output logic                             tx_ready,
  input  wire logic                        integrity_error_event,
  input  wire logic                        decrypt_error_event,
  input  wire logic [3:0]                  supply_code,
  output logic                             irq
);
  import tss_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_TX,
    ST_SPACING
  } tss_state_type;

  // Write channel holding
  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic [DATA_W-1:0]   w_data;
  logic [3:0]          w_strb;
  logic                do_write;
  logic                lane0;

  // Registers
  tss_settle_type      settle;
  logic [3:0]          battery_threshold;
  logic                battery_monitor_enable;
  logic                upper_layer_integrity_error;
  logic                decrypt_error_flag;
  logic                low_battery_flag;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_mask;

  // Read side effects
  logic                rd_take;
  logic                rd_sec;
  logic                rd_irq;

  // Sequencer
  tss_state_type       state;
  tss_state_type       next_state;
  logic                timer_start;
  logic [3:0]          timer_symbols;
  logic                timer_done;
  logic [3:0]          supply_level;
  logic                next_low_battery;
  logic [4:0]          gap_sum;
  tss_event_type       events;

  // True for an address that names a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == reg_addr(IDX_TX_SETTLE)) || (a == reg_addr(IDX_SEC_STATUS)) ||
           (a == reg_addr(IDX_RF_CONFIG5)) || (a == reg_addr(IDX_RF_CONFIG6)) ||
           (a == reg_addr(IDX_IRQ_STATUS)) || (a == reg_addr(IDX_IRQ_MASK)) ||
           (a == reg_addr(IDX_LINK_STATE));
  endfunction

  // True for a write to the given register with lane 0 enabled
  function automatic logic wr_hit(input logic [9:0] idx);
    return do_write && lane0 && (aw_addr == reg_addr(idx));
  endfunction

  // Supply code comes from a free-running converter
  tss_input_sync #(
    .WIDTH     (4)
  ) u_supply_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .async_in  (supply_code),
    .level_out (supply_level)
  );

  // Settle and spacing period counter
  tss_symbol_timer #(
    .SYMBOL_CYCLES (SYMBOL_CYCLES)
  ) u_timer (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .start         (timer_start),
    .symbols       (timer_symbols),
    .done          (timer_done)
  );

  // Write address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign lane0         = w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response, error for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Settle register with reset defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle.osc_settle_period <= SETTLE_RST;
      settle.min_short_spacing <= MIN_SPACING_RST;
    end else if (wr_hit(IDX_TX_SETTLE)) begin
      settle <= tss_settle_type'(w_data[REG_W-1:0]);
    end
  end

  // Battery threshold and monitor enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      battery_threshold      <= '0;
      battery_monitor_enable <= 1'b0;
    end else begin
      if (wr_hit(IDX_RF_CONFIG5)) begin
        battery_threshold <= w_data[THRESH_LSB +: 4];
      end
      if (wr_hit(IDX_RF_CONFIG6)) begin
        battery_monitor_enable <= w_data[BAT_ENABLE_BIT];
      end
    end
  end

  // Supply below threshold only while monitoring is enabled
  assign next_low_battery = battery_monitor_enable && (supply_level < battery_threshold);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_battery_flag <= 1'b0;
    end else begin
      low_battery_flag <= next_low_battery;
    end
  end

  // Error flags; a new error wins over its clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_layer_integrity_error <= 1'b0;
      decrypt_error_flag          <= 1'b0;
    end else begin
      if (integrity_error_event) begin
        upper_layer_integrity_error <= 1'b1;
      end else if (wr_hit(IDX_SEC_STATUS) && w_data[SEC_INTEGRITY_BIT]) begin
        upper_layer_integrity_error <= 1'b0;
      end
      if (decrypt_error_event) begin
        decrypt_error_flag <= 1'b1;
      end else if (rd_sec) begin
        decrypt_error_flag <= 1'b0;
      end
    end
  end

  // Interrupt sources
  assign events.integrity_error = integrity_error_event;
  assign events.decrypt_error   = decrypt_error_event;
  assign events.low_battery     = next_low_battery && !low_battery_flag;
  assign events.tx_start        = (state == ST_SETTLE) && timer_done;
  assign events.spacing_done    = (state == ST_SPACING) && timer_done;

  // Sticky status, cleared by reading it; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= events | (irq_status & {IRQ_W{!rd_irq}});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= '0;
    end else if (wr_hit(IDX_IRQ_MASK)) begin
      irq_mask <= w_data[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_sec        = rd_take && (s_axi_araddr == reg_addr(IDX_SEC_STATUS));
  assign rd_irq        = rd_take && (s_axi_araddr == reg_addr(IDX_IRQ_STATUS));
  assign gap_sum       = {1'b0, settle.osc_settle_period} + {1'b0, settle.min_short_spacing};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= '0;
      unique case (s_axi_araddr)
        reg_addr(IDX_TX_SETTLE): begin
          s_axi_rdata[REG_W-1:0] <= settle;
        end
        reg_addr(IDX_SEC_STATUS): begin
          s_axi_rdata[SEC_INTEGRITY_BIT] <= upper_layer_integrity_error;
          s_axi_rdata[SEC_BATTERY_BIT]   <= low_battery_flag;
          s_axi_rdata[SEC_DECRYPT_BIT]   <= decrypt_error_flag;
        end
        reg_addr(IDX_RF_CONFIG5): begin
          s_axi_rdata[THRESH_LSB +: 4] <= battery_threshold;
        end
        reg_addr(IDX_RF_CONFIG6): begin
          s_axi_rdata[BAT_ENABLE_BIT] <= battery_monitor_enable;
        end
        reg_addr(IDX_IRQ_STATUS): begin
          s_axi_rdata[IRQ_W-1:0] <= irq_status;
        end
        reg_addr(IDX_IRQ_MASK): begin
          s_axi_rdata[IRQ_W-1:0] <= irq_mask;
        end
        reg_addr(IDX_LINK_STATE): begin
          s_axi_rdata[LINK_SETTLE_BIT]  <= (state == ST_SETTLE);
          s_axi_rdata[LINK_SPACING_BIT] <= (state == ST_SPACING);
          s_axi_rdata[LINK_SUM_OK_BIT]  <= (gap_sum == SIFS_TOTAL);
        end
        default: begin
          s_axi_rdata <= '0;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Transmit sequencer next state and timer loads
  always_comb begin
    next_state    = state;
    timer_start   = 1'b0;
    timer_symbols = settle.osc_settle_period;
    unique case (state)
      ST_IDLE: begin
        if (tx_request) begin
          timer_start = 1'b1;
          next_state  = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (timer_done) begin
          next_state = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_done) begin
          timer_start   = 1'b1;
          timer_symbols = settle.min_short_spacing;
          next_state    = ST_SPACING;
        end
      end
      ST_SPACING: begin
        if (timer_done) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Transmit go pulse after the settle period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= events.tx_start;
    end
  end

  assign tx_ready = (state == ST_IDLE);

endmodule

// >>> verilog/tss_pkg.sv
// Shared constants, register map and carrier types of the settle/status slice
package tss_pkg;

  // Bus geometry
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 8;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_TX_SETTLE   = 10'h02e;
  localparam logic [9:0]  IDX_SEC_STATUS  = 10'h02f;
  localparam logic [9:0]  IDX_RF_CONFIG5  = 10'h205;
  localparam logic [9:0]  IDX_RF_CONFIG6  = 10'h206;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h040;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h041;
  localparam logic [9:0]  IDX_LINK_STATE  = 10'h042;

  // Reset values of the settle register fields and the total gap that their sum is checked against
  localparam logic [3:0]  SETTLE_RST      = 4'h7;
  localparam logic [3:0]  MIN_SPACING_RST = 4'h5;
  localparam logic [4:0]  SIFS_TOTAL      = 5'h0c;

  // Field positions
  localparam int          SEC_INTEGRITY_BIT = 6;
  localparam int          SEC_BATTERY_BIT   = 5;
  localparam int          SEC_DECRYPT_BIT   = 2;
  localparam int          THRESH_LSB        = 4;
  localparam int          BAT_ENABLE_BIT    = 3;
  localparam int          LINK_SETTLE_BIT   = 0;
  localparam int          LINK_SPACING_BIT  = 1;
  localparam int          LINK_SUM_OK_BIT   = 2;

  // Symbol timing
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          SYMBOL_NS       = 16000;
  localparam int          SYMBOL_CYCLES   = SYMBOL_NS / CLK_PERIOD_NS;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // Settle register layout, high nibble first
  typedef struct packed {
    logic [3:0] osc_settle_period;
    logic [3:0] min_short_spacing;
  } tss_settle_type;

  // Interrupt sources, bit 0 is the integrity error
  typedef struct packed {
    logic spacing_done;
    logic tx_start;
    logic low_battery;
    logic decrypt_error;
    logic integrity_error;
  } tss_event_type;

  localparam int          IRQ_W           = $bits(tss_event_type);

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// >>> verilog/tss_input_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module tss_input_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  import tss_pkg::*;

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain, first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Whole word moves only once stages two and three agree, so a torn code is never passed on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= '0;
    end else if (stage2 == stage3) begin
      level_out <= stage3;
    end
  end

endmodule

// >>> verilog/tss_symbol_timer.sv
// Counts a number of symbol periods and pulses when they have elapsed
`timescale 1ns/1ns
module tss_symbol_timer #(
  parameter int SYMBOL_CYCLES = 2000
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic [3:0] symbols,
  output logic            done
);
  import tss_pkg::*;

  localparam int CYC_W = $clog2(SYMBOL_CYCLES);

  logic             active;
  logic [3:0]       sym_left;
  logic [CYC_W-1:0] cycles;

  // Symbol and cycle counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active   <= 1'b0;
      sym_left <= '0;
      cycles   <= '0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        active   <= 1'b1;
        sym_left <= symbols;
        cycles   <= '0;
      end else if (active) begin
        if (sym_left == '0) begin
          active <= 1'b0;
          done   <= 1'b1;
        end else if (cycles == CYC_W'(SYMBOL_CYCLES - 1)) begin
          cycles   <= '0;
          sym_left <= sym_left - 4'd1;
        end else begin
          cycles <= cycles + CYC_W'(1);
        end
      end
    end
  end

endmodule

// >>> verif/tss_settle_status_props.sv
// Port-level checker of bus handshakes and transmit sequencing
`timescale 1ns/1ns
module tss_settle_status_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_request,
  input wire logic        tx_start,
  input wire logic        tx_ready
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus responses
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write accepted while busy");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
  property p_r_err; s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rdata == 32'h0000_0000; endproperty
  a_r_err: assert property (p_r_err) else $error("error read carries data");

  // Transmit sequencer
  property p_tx_pulse; tx_start |=> !tx_start; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("start pulse too long");
  property p_tx_take; tx_request && tx_ready |=> !tx_ready; endproperty
  a_tx_take: assert property (p_tx_take) else $error("request not taken");
  property p_tx_busy; tx_start |-> !tx_ready ##1 !tx_ready; endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("ready during transmit");

  // Main scenarios
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_tx: cover property (tx_start);
endmodule

// >>> verif/tss_settle_status_bench.sv
// Self-checking bench of the settle/spacing and security status slice
`timescale 1ns/1ns
module tss_settle_status_bench;
  import tss_pkg::*;
  localparam int SC = 4;
  logic              aclk                  = 1'b0;
  logic              aresetn               = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr          = '0;
  logic              s_axi_awvalid         = 1'b0;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata           = '0;
  logic [3:0]        s_axi_wstrb           = '0;
  logic              s_axi_wvalid          = 1'b0;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready          = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr          = '0;
  logic              s_axi_arvalid         = 1'b0;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready          = 1'b0;
  logic              tx_request            = 1'b0;
  logic              tx_done               = 1'b0;
  logic              tx_start;
  logic              tx_ready;
  logic              integrity_error_event = 1'b0;
  logic              decrypt_error_event   = 1'b0;
  logic [3:0]        supply_code           = 4'hf;
  logic              irq;
  int                fail_count            = 0;
  int                n_tests               = 0;

  tss_settle_status #(.SYMBOL_CYCLES(SC)) dut (.*);

  // Clock, 8 ns period
  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write; handshakes judged at the negedge before each edge
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask

  // Bus read
  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic wrk(input logic [9:0] idx, input logic [31:0] d);
    logic [1:0] r;
    wr(idx, d, 4'hf, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic t_reset;
    rdc(IDX_TX_SETTLE, 32'h0000_0075);
    rdc(IDX_SEC_STATUS, 32'h0000_0000);
    rdc(IDX_LINK_STATE, 32'h0000_0004);
    $display("t_reset done");
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    wrk(IDX_TX_SETTLE, 32'h0000_0093);
    rdc(IDX_TX_SETTLE, 32'h0000_0093);
    rdc(IDX_LINK_STATE, 32'h0000_0004);
    wr(IDX_TX_SETTLE, 32'h0000_0011, 4'h0, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rdc(IDX_TX_SETTLE, 32'h0000_0093);
    wr(10'h3ff, 32'h0000_00ff, 4'hf, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(10'h3ff, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wrk(IDX_TX_SETTLE, 32'h0000_0023);
    rdc(IDX_LINK_STATE, 32'h0000_0000);
    $display("t_regs done");
  endtask

  task automatic t_status;
    wrk(IDX_IRQ_MASK, 32'h0000_0001);
    rdc(IDX_IRQ_STATUS, 32'h0000_0000);
    @(posedge aclk) decrypt_error_event <= 1'b1;
    @(posedge aclk) decrypt_error_event <= 1'b0;
    @(negedge aclk) chk({31'h0, irq}, 32'h0000_0000);
    @(posedge aclk) integrity_error_event <= 1'b1;
    @(posedge aclk) integrity_error_event <= 1'b0;
    @(negedge aclk) chk({31'h0, irq}, 32'h0000_0001);
    rdc(IDX_SEC_STATUS, 32'h0000_0044);
    rdc(IDX_SEC_STATUS, 32'h0000_0040);
    wrk(IDX_SEC_STATUS, 32'h0000_0040);
    rdc(IDX_SEC_STATUS, 32'h0000_0000);
    rdc(IDX_IRQ_STATUS, 32'h0000_0003);
    @(negedge aclk) chk({31'h0, irq}, 32'h0000_0000);
    $display("t_status done");
  endtask

  task automatic t_battery;
    wrk(IDX_RF_CONFIG5, 32'h0000_0080);
    @(posedge aclk) supply_code <= 4'h3;
    repeat (8) @(posedge aclk);
    rdc(IDX_SEC_STATUS, 32'h0000_0000);
    wrk(IDX_RF_CONFIG6, 32'h0000_0008);
    repeat (8) @(posedge aclk);
    rdc(IDX_SEC_STATUS, 32'h0000_0020);
    @(posedge aclk) supply_code <= 4'hc;
    repeat (8) @(posedge aclk);
    rdc(IDX_SEC_STATUS, 32'h0000_0000);
    rdc(IDX_IRQ_STATUS, 32'h0000_0004);
    $display("t_battery done");
  endtask

  // Settle wait before start, spacing wait before ready
  task automatic t_tx(input int s, input int m);
    int n;
    wrk(IDX_TX_SETTLE, 32'(s * 16 + m));
    @(posedge aclk) tx_request <= 1'b1;
    @(posedge aclk) tx_request <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (tx_start !== 1'b1 && n < 500);
    chk(32'(n >= s * SC + 2 && n <= s * SC + s + 5), 32'h1);
    chk({31'h0, tx_ready}, 32'h0);
    @(posedge aclk) tx_done <= 1'b1;
    @(posedge aclk) tx_done <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 500);
    chk(32'(n >= m * SC && n <= m * SC + m + 5), 32'h1);
    rdc(IDX_IRQ_STATUS, 32'h0000_0018);
    $display("t_tx done settle %0d spacing %0d", s, m);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_regs;
    t_status;
    t_battery;
    t_tx(9, 3);
    t_tx(7, 5);
    t_tx(1, 15);
    end_of_test;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_of_test;
  end
endmodule

bind tss_settle_status tss_settle_status_props u_props (.*);
